// ### logic/sbs_map.svh
`ifndef SBS_MAP_SVH
`define SBS_MAP_SVH
// ****************************************
// Register offsets (9-bit data address)
// ****************************************
`define SBS_OFS_INDIRECT     9'h180
`define SBS_OFS_PRESCALE     9'h181
`define SBS_OFS_PCL          9'h182
`define SBS_OFS_STATUS       9'h183
`define SBS_OFS_POINTER      9'h184
`define SBS_OFS_PORTB_DIR    9'h186
`define SBS_OFS_PROGRAM_COUNTER_HIGH_LATCH       9'h18A
`define SBS_OFS_INTCTL       9'h18B
`define SBS_OFS_NVM_CTL      9'h18C
`define SBS_OFS_NVM_UNLOCK   9'h18D
`define SBS_OFS_LOW7         7'h03
// ****************************************
// Status and prescale field positions
// ****************************************
`define SBS_ST_IRP           7
`define SBS_ST_RP_HI         6
`define SBS_ST_RP_LO         5
`define SBS_ST_TO            4
`define SBS_ST_PD            3
`define SBS_ST_Z             2
`define SBS_ST_DC            1
`define SBS_ST_C             0
`define SBS_OPT_PSA          3
// ****************************************
// Reset values
// ****************************************
`define SBS_RST_STATUS_POR   8'h18
`define SBS_RST_PRESCALE     8'hFF
`define SBS_RST_PCL          8'h00
`define SBS_RST_PORTB_DIR    8'hFF
`define SBS_RST_PROGRAM_COUNTER_HIGH_LATCH       5'h00
`define SBS_RST_INTCTL       8'h00
`define SBS_RST_NVM_CTL      8'h00
`define SBS_RST_POINTER      8'h00
`endif

// ### logic/sbs_pkg.sv
`default_nettype none
package sbs_pkg;
	typedef enum logic [3:0] {
		SBS_FLAG_NONE  = 4'h1,
		SBS_FLAG_Z     = 4'h2,
		SBS_FLAG_ZDCC  = 4'h4,
		SBS_FLAG_C     = 4'h8
	} sbs_flag_mode_t;
	typedef enum logic [3:0] {
		SBS_RST_RUN    = 4'h1,
		SBS_RST_POWER  = 4'h2,
		SBS_RST_OTHER  = 4'h4,
		SBS_RST_HOLD   = 4'h8
	} sbs_reset_state_t;
endpackage
`default_nettype wire

// ### logic/sbs_regs.sv
// The address-and-strobe port was chosen for this implementation.
`include "sbs_map.svh"
`default_nettype none
module sbs_regs
	import sbs_pkg::*;
(
	input  wire logic        i_core_clk,
	input  wire logic        i_reset,
	input  wire logic        i_power_on_reset,
	input  wire logic        i_external_reset_pin,
	input  wire logic        i_watchdog_timeout,
	input  wire logic        i_watchdog_clear_instr,
	input  wire logic        i_sleep_instr,
	input  wire logic [8:0]  i_addr,
	input  wire logic [7:0]  i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	input  wire logic        i_addr_indirect,
	input  wire logic [6:0]  i_instr_addr,
	input  wire logic        i_alu_valid,
	input  wire logic [3:0]  i_alu_mode,
	input  wire logic        i_alu_sub,
	input  wire logic [7:0]  i_alu_a,
	input  wire logic [7:0]  i_alu_b,
	input  wire logic [7:0]  i_alu_result,
	input  wire logic        i_rot_out_bit,
	input  wire logic        i_clear_status,
	output logic      [7:0]  o_rdata,
	output logic      [8:0]  o_direct_addr,
	output logic      [8:0]  o_target_addr,
	output logic      [7:0]  o_status,
	output logic      [7:0]  o_prescale_cfg,
	output logic             o_timer_zero_unprescaled,
	output logic      [7:0]  o_port_b_direction,
	output logic      [4:0]  o_pc_high_latch,
	output logic      [7:0]  o_pc_low,
	output logic             o_nvm_unlock_strobe,
	output logic      [7:0]  o_nvm_unlock_data
);
	// ****************************************
	// Reset cause synchronisation
	// ****************************************
	logic       por_s1_reg, por_s2_reg, pin_s1_reg, pin_s2_reg;
	logic       wdt_s1_reg, wdt_s2_reg, wdt_d_reg;
	logic       other_rst;
	logic       wdt_evt;
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			por_s1_reg <= 1'b1;
			por_s2_reg <= 1'b1;
			pin_s1_reg <= 1'b0;
			pin_s2_reg <= 1'b0;
			wdt_s1_reg <= 1'b0;
			wdt_s2_reg <= 1'b0;
			wdt_d_reg  <= 1'b0;
		end else begin
			por_s1_reg <= i_power_on_reset;
			por_s2_reg <= por_s1_reg;
			pin_s1_reg <= i_external_reset_pin;
			pin_s2_reg <= pin_s1_reg;
			wdt_s1_reg <= i_watchdog_timeout;
			wdt_s2_reg <= wdt_s1_reg;
			wdt_d_reg  <= wdt_s2_reg;
		end
	end
	// Watchdog time-out both clears the expiry flag and resets the core registers
	assign wdt_evt   = wdt_s2_reg & ~wdt_d_reg;
	assign other_rst = (pin_s2_reg | wdt_evt) & ~por_s2_reg;

	// ****************************************
	// Address decoding
	// ****************************************
	function automatic logic [6:0] sbs_low7(input logic [8:0] a);
		sbs_low7 = a[6:0];
	endfunction

	logic [7:0] status_reg, pointer_reg;
	logic [8:0] eff_addr;
	logic       is_indirect;
	assign o_direct_addr = {status_reg[`SBS_ST_RP_HI:`SBS_ST_RP_LO], i_instr_addr};
	assign is_indirect   = (sbs_low7(i_addr) == sbs_low7(`SBS_OFS_INDIRECT));
	// No storage at the indirect port: address comes from the pointer
	assign eff_addr      = is_indirect ? {status_reg[`SBS_ST_IRP], pointer_reg} : i_addr;
	assign o_target_addr = i_addr_indirect ? {status_reg[`SBS_ST_IRP], pointer_reg} : o_direct_addr;

	logic hit_status, wr_status;
	// Status and pointer decode on the low 7 bits so every bank sees them
	assign hit_status = (sbs_low7(eff_addr) == `SBS_OFS_LOW7);
	assign wr_status  = i_wr & hit_status;

	// ****************************************
	// Flag computation
	// ****************************************
	logic [4:0] nib_sum;
	logic [8:0] byte_sum;
	logic [7:0] b_eff;
	logic       flag_op;
	// A flag-writing op owns Z, DC and C, so a software write to them is dropped
	assign flag_op = i_alu_valid & (i_alu_mode inside {SBS_FLAG_Z, SBS_FLAG_ZDCC, SBS_FLAG_C});
	always_comb begin
		// Subtract adds the two's complement, so carries read as inverted borrows
		b_eff    = i_alu_sub ? (~i_alu_b) : i_alu_b;
		nib_sum  = {1'b0, i_alu_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, i_alu_sub};
		byte_sum = {1'b0, i_alu_a} + {1'b0, b_eff} + {8'h00, i_alu_sub};
	end

	// ****************************************
	// Status register
	// ****************************************
	logic [7:0] status_next;
	always_comb begin
		status_next = status_reg;
		if (wr_status) begin
			// Expiry and power-down bits never take software data
			status_next[7:5] = i_wdata[7:5];
			if (!flag_op)
				status_next[2:0] = i_wdata[2:0];
		end
		if (i_clear_status) begin
			status_next[7:5] = 3'h0;
			status_next[`SBS_ST_Z] = 1'b1;
		end
		if (i_alu_valid) begin
			case (i_alu_mode)
				SBS_FLAG_Z: begin
					status_next[`SBS_ST_Z] = (i_alu_result == 8'h00);
				end
				SBS_FLAG_ZDCC: begin
					status_next[`SBS_ST_Z]  = (i_alu_result == 8'h00);
					status_next[`SBS_ST_DC] = nib_sum[4];
					status_next[`SBS_ST_C]  = byte_sum[8];
				end
				SBS_FLAG_C: begin
					status_next[`SBS_ST_C] = i_rot_out_bit;
				end
				default: begin
					status_next = status_next;
				end
			endcase
		end
		if (wdt_evt)
			status_next[`SBS_ST_TO] = 1'b0;
		if (i_sleep_instr) begin
			status_next[`SBS_ST_TO] = 1'b1;
			status_next[`SBS_ST_PD] = 1'b0;
		end
		if (i_watchdog_clear_instr) begin
			status_next[`SBS_ST_TO] = 1'b1;
			status_next[`SBS_ST_PD] = 1'b1;
		end
	end

	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			status_reg <= `SBS_RST_STATUS_POR;
		end else if (por_s2_reg) begin
			status_reg <= `SBS_RST_STATUS_POR;
		end else if (other_rst) begin
			// Bank bits clear; reset-cause and arithmetic flags kept
			status_reg <= {3'h0, status_next[4:0]};
		end else begin
			status_reg <= status_next;
		end
	end

	// ****************************************
	// Plain software registers
	// ****************************************
	function automatic logic hit(input logic [8:0] a, input logic [8:0] ofs);
		hit = (sbs_low7(a) == sbs_low7(ofs));
	endfunction

	logic [7:0] prescale_reg, portb_dir_reg, pcl_reg, intctl_reg, nvm_ctl_reg;
	logic [4:0] program_counter_high_latch_reg;
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			prescale_reg  <= `SBS_RST_PRESCALE;
			portb_dir_reg <= `SBS_RST_PORTB_DIR;
			pcl_reg       <= `SBS_RST_PCL;
			program_counter_high_latch_reg    <= `SBS_RST_PROGRAM_COUNTER_HIGH_LATCH;
			intctl_reg    <= `SBS_RST_INTCTL;
			nvm_ctl_reg   <= `SBS_RST_NVM_CTL;
		end else if (por_s2_reg | other_rst) begin
			prescale_reg  <= `SBS_RST_PRESCALE;
			portb_dir_reg <= `SBS_RST_PORTB_DIR;
			pcl_reg       <= `SBS_RST_PCL;
			program_counter_high_latch_reg    <= `SBS_RST_PROGRAM_COUNTER_HIGH_LATCH;
			intctl_reg    <= `SBS_RST_INTCTL;
			nvm_ctl_reg   <= `SBS_RST_NVM_CTL;
		end else if (i_wr) begin
			if (hit(eff_addr, `SBS_OFS_PRESCALE))
				prescale_reg <= i_wdata;
			if (hit(eff_addr, `SBS_OFS_PORTB_DIR))
				portb_dir_reg <= i_wdata;
			if (hit(eff_addr, `SBS_OFS_PCL))
				pcl_reg <= i_wdata;
			if (hit(eff_addr, `SBS_OFS_PROGRAM_COUNTER_HIGH_LATCH))
				program_counter_high_latch_reg <= i_wdata[4:0];
			if (hit(eff_addr, `SBS_OFS_INTCTL))
				intctl_reg <= i_wdata;
			if (hit(eff_addr, `SBS_OFS_NVM_CTL))
				nvm_ctl_reg <= i_wdata;
		end
	end

	// Pointer survives pin and watchdog resets; only i_reset and power-on clear it
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			pointer_reg <= `SBS_RST_POINTER;
		end else if (por_s2_reg) begin
			// Power-on in run starts the pointer afresh
			pointer_reg <= `SBS_RST_POINTER;
		end else if (i_wr && !is_indirect && hit(i_addr, `SBS_OFS_POINTER)) begin
			pointer_reg <= i_wdata;
		end
	end

	// ****************************************
	// Unlock strobe, no storage
	// ****************************************
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			o_nvm_unlock_strobe <= 1'b0;
			o_nvm_unlock_data   <= 8'h00;
		end else begin
			o_nvm_unlock_strobe <= i_wr & hit(eff_addr, `SBS_OFS_NVM_UNLOCK);
			o_nvm_unlock_data   <= i_wdata;
		end
	end

	// ****************************************
	// Read port
	// ****************************************
	logic [7:0] rd_mux;
	always_comb begin
		rd_mux = 8'h00;
		case (sbs_low7(eff_addr))
			sbs_low7(`SBS_OFS_PRESCALE):  rd_mux = prescale_reg;
			sbs_low7(`SBS_OFS_PCL):       rd_mux = pcl_reg;
			sbs_low7(`SBS_OFS_STATUS):    rd_mux = status_reg;
			sbs_low7(`SBS_OFS_POINTER):   rd_mux = pointer_reg;
			sbs_low7(`SBS_OFS_PORTB_DIR): rd_mux = portb_dir_reg;
			sbs_low7(`SBS_OFS_PROGRAM_COUNTER_HIGH_LATCH):    rd_mux = {3'h0, program_counter_high_latch_reg};
			sbs_low7(`SBS_OFS_INTCTL):    rd_mux = intctl_reg;
			sbs_low7(`SBS_OFS_NVM_CTL):   rd_mux = nvm_ctl_reg;
			default:                      rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			o_rdata <= 8'h00;
		end else begin
			o_rdata <= i_rd ? rd_mux : 8'h00;
		end
	end

	assign o_status                 = status_reg;
	assign o_prescale_cfg           = prescale_reg;
	assign o_timer_zero_unprescaled = prescale_reg[`SBS_OPT_PSA];
	assign o_port_b_direction       = portb_dir_reg;
	assign o_pc_high_latch          = program_counter_high_latch_reg;
	assign o_pc_low                 = pcl_reg;

	// ****************************************
	// Checks
	// ****************************************
	logic [1:0] sd;
	always_comb sd = {i_alu_valid, i_clear_status};
	flag_override_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(i_alu_valid && i_alu_mode == SBS_FLAG_ZDCC && !por_s2_reg && !other_rst)
		|=> status_reg[`SBS_ST_Z] == ($past(i_alu_result) == 8'h00))
		else $error("zero flag not taken from result");
	flag_protect_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(!i_sleep_instr && !i_watchdog_clear_instr && !wdt_evt && !por_s2_reg)
		|=> $stable(status_reg[4:3]))
		else $error("expiry or power-down flag changed");
	status_clear_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(i_clear_status && !i_alu_valid && !por_s2_reg) |=> status_reg[7:5] == 3'h0 && status_reg[2])
		else $error("status clear wrong");
	indirect_bank_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
		i_addr_indirect |-> o_target_addr[8] == status_reg[7])
		else $error("indirect bank wrong");
	sleep_flags_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(i_sleep_instr && !i_watchdog_clear_instr && !por_s2_reg && !other_rst) |=> status_reg[4:3] == 2'b10)
		else $error("sleep flags wrong");
	wdt_flag_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(wdt_evt && !i_sleep_instr && !i_watchdog_clear_instr && !por_s2_reg) |=> !status_reg[4])
		else $error("expiry flag not cleared");
	carry_add_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(i_alu_valid && i_alu_mode == SBS_FLAG_ZDCC && !i_alu_sub && !por_s2_reg && !other_rst)
		|=> status_reg[0] == (({1'b0, $past(i_alu_a)} + {1'b0, $past(i_alu_b)}) > 9'h0FF))
		else $error("carry wrong");
	unmapped_zero_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(i_rd && sbs_low7(i_addr) == 7'h05) |=> o_rdata == 8'h00)
		else $error("unmapped read nonzero");
	psa_rate_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(i_wr && hit(eff_addr, `SBS_OFS_PRESCALE) && !por_s2_reg && !other_rst)
		|=> o_timer_zero_unprescaled == $past(i_wdata[`SBS_OPT_PSA]))
		else $error("prescaler assignment wrong");
	direct_bank_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(wr_status && !i_clear_status && !por_s2_reg && !other_rst)
		|=> o_direct_addr[8:7] == $past(i_wdata[6:5]))
		else $error("direct bank bits wrong");
	flag_block_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(wr_status && i_alu_valid && i_alu_mode == SBS_FLAG_Z && !por_s2_reg)
		|=> status_reg[1:0] == $past(status_reg[1:0]))
		else $error("carry flags took a blocked write");
	zero_only_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(i_alu_valid && i_alu_mode == SBS_FLAG_Z && !por_s2_reg)
		|=> status_reg[`SBS_ST_Z] == ($past(i_alu_result) == 8'h00))
		else $error("zero flag wrong");
	digit_carry_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(i_alu_valid && i_alu_mode == SBS_FLAG_ZDCC && !i_alu_sub && !por_s2_reg)
		|=> status_reg[1] == (({1'b0, $past(i_alu_a[3:0])} + {1'b0, $past(i_alu_b[3:0])}) > 5'h0F))
		else $error("digit carry wrong");
	borrow_sub_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(i_alu_valid && i_alu_mode == SBS_FLAG_ZDCC && i_alu_sub && !por_s2_reg)
		|=> status_reg[0] == ($past(i_alu_a) >= $past(i_alu_b)))
		else $error("inverted borrow wrong");
	rotate_carry_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(i_alu_valid && i_alu_mode == SBS_FLAG_C && !por_s2_reg)
		|=> status_reg[0] == $past(i_rot_out_bit))
		else $error("rotate carry wrong");
	status_read_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(i_rd && sbs_low7(i_addr) == `SBS_OFS_LOW7) |=> o_rdata == $past(status_reg))
		else $error("status not readable in bank");
	indirect_read_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(i_rd && is_indirect && sbs_low7({status_reg[7], pointer_reg}) == sbs_low7(`SBS_OFS_PORTB_DIR))
		|=> o_rdata == $past(portb_dir_reg))
		else $error("indirect read not redirected");
	other_reset_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
		other_rst |=> o_port_b_direction == `SBS_RST_PORTB_DIR && status_reg[7:5] == 3'h0)
		else $error("other reset values wrong");
	keep_pointer_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(other_rst && !i_wr) |=> $stable(pointer_reg))
		else $error("pointer lost on other reset");
	latch_five_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(i_wr && hit(eff_addr, `SBS_OFS_PROGRAM_COUNTER_HIGH_LATCH) && !por_s2_reg && !other_rst)
		|=> o_pc_high_latch == $past(i_wdata[4:0]))
		else $error("high latch wrong");
	unlock_strobe_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(i_wr && hit(eff_addr, `SBS_OFS_NVM_UNLOCK))
		|=> o_nvm_unlock_strobe && o_nvm_unlock_data == $past(i_wdata))
		else $error("unlock strobe missing");
	// ****************************************
	// Covers
	// ****************************************
	sleep_c: cover property (@(posedge i_core_clk) i_sleep_instr);
	sub_c: cover property (@(posedge i_core_clk) i_alu_valid && i_alu_sub);
	clr_c: cover property (@(posedge i_core_clk) sd == 2'b01);
	ind_c: cover property (@(posedge i_core_clk) i_rd && is_indirect);
	wdt_c: cover property (@(posedge i_core_clk) wdt_evt);
endmodule
`default_nettype wire

// ### verif/sbs_regs_tb_top.sv
`include "sbs_map.svh"
`default_nettype none
module sbs_regs_tb_top
	import sbs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// ****************************************
	// Stimulus and observed signals
	// ****************************************
	logic       i_core_clk, i_reset, i_power_on_reset, i_external_reset_pin, i_watchdog_timeout;
	logic       i_watchdog_clear_instr, i_sleep_instr, i_wr, i_rd, i_addr_indirect, i_alu_valid;
	logic       i_alu_sub, i_rot_out_bit, i_clear_status, o_timer_zero_unprescaled, o_nvm_unlock_strobe;
	logic [8:0] i_addr, o_direct_addr, o_target_addr;
	logic [7:0] i_wdata, i_alu_a, i_alu_b, i_alu_result, o_rdata, o_status, o_prescale_cfg;
	logic [7:0] o_port_b_direction, o_pc_low, o_nvm_unlock_data;
	logic [6:0] i_instr_addr;
	logic [4:0] o_pc_high_latch;
	logic [3:0] i_alu_mode;
	int         err_total, checks_done, n;
	sbs_regs uut (.i_core_clk, .i_reset, .i_power_on_reset, .i_external_reset_pin, .i_watchdog_timeout,
		.i_watchdog_clear_instr, .i_sleep_instr, .i_addr, .i_wdata, .i_wr, .i_rd, .i_addr_indirect,
		.i_instr_addr, .i_alu_valid, .i_alu_mode, .i_alu_sub, .i_alu_a, .i_alu_b, .i_alu_result,
		.i_rot_out_bit, .i_clear_status, .o_rdata, .o_direct_addr, .o_target_addr, .o_status,
		.o_prescale_cfg, .o_timer_zero_unprescaled, .o_port_b_direction, .o_pc_high_latch, .o_pc_low,
		.o_nvm_unlock_strobe, .o_nvm_unlock_data);
	always #4 i_core_clk = ~i_core_clk;
	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	// Samples settle one step after the edge so no update race decides the outcome
	task automatic hold(input int c);
		repeat (c) @(posedge i_core_clk);
		#1;
	endtask
	task automatic tmo(input string what);
		if (n >= 20) begin
			chk(1'b0, 1'b1, what);
			results();
		end
	endtask
	task automatic wr(input logic [8:0] a, input logic [7:0] d);
		@(posedge i_core_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [8:0] a, input logic [7:0] exp);
		@(posedge i_core_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		#1;
		chk(o_rdata, exp, "read data");
	endtask
	// Expected flags come from the operands, never from the block's own result
	task automatic alu(input logic [3:0] m, input logic s, input logic [7:0] a, input logic [7:0] b,
		input logic r);
		logic [8:0] sum;
		logic [4:0] nib;
		logic [7:0] exp;
		sum = {1'b0, a} + {1'b0, s ? ~b : b} + s;
		nib = {1'b0, a[3:0]} + {1'b0, s ? ~b[3:0] : b[3:0]} + s;
		exp = o_status;
		if (m == SBS_FLAG_Z || m == SBS_FLAG_ZDCC) exp[2] = (sum[7:0] == 8'h00);
		if (m == SBS_FLAG_ZDCC) exp[1:0] = {nib[4], sum[8]};
		if (m == SBS_FLAG_C) exp[0] = r;
		@(posedge i_core_clk);
		i_alu_valid <= 1'b1;
		i_alu_mode <= m;
		i_alu_sub <= s;
		i_alu_a <= a;
		i_alu_b <= b;
		i_alu_result <= sum[7:0];
		i_rot_out_bit <= r;
		@(posedge i_core_clk);
		i_alu_valid <= 1'b0;
		#1;
		chk(o_status, exp, "alu flags");
	endtask
	// Status write and flag op in one cycle: the op keeps the flags it owns
	task automatic alu_wr(input logic [3:0] m, input logic [7:0] d, input logic [7:0] a, input logic [7:0] b,
		input logic [7:0] exp);
		@(posedge i_core_clk);
		i_wr <= 1'b1;
		i_addr <= `SBS_OFS_STATUS;
		i_wdata <= d;
		i_alu_valid <= 1'b1;
		i_alu_mode <= m;
		i_alu_sub <= 1'b0;
		i_alu_a <= a;
		i_alu_b <= b;
		i_alu_result <= a + b;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
		i_alu_valid <= 1'b0;
		#1;
		chk(o_status, exp, "op overrides flag write");
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		chk(o_status, 8'h18, "status after power reset");
		chk(o_prescale_cfg, 8'hFF, "prescale reset");
		chk(o_timer_zero_unprescaled, 1'b1, "timer unprescaled");
		chk(o_port_b_direction, 8'hFF, "direction reset");
		chk(o_pc_high_latch, 5'h00, "high latch reset");
		rd(`SBS_OFS_PCL, 8'h00);
		$display("test reset done");
	endtask
	task automatic t_banks();
		for (int i = 0; i < 4; i++) begin
			wr({i[1:0], `SBS_OFS_LOW7}, {i[0], i[1:0], 5'h05});
			chk(o_direct_addr, {i[1:0], 7'h2A}, "direct address");
			rd({i[1:0], `SBS_OFS_LOW7}, {i[0], i[1:0], 5'h1D});
		end
		$display("test banks done");
	endtask
	task automatic t_indirect();
		wr(`SBS_OFS_POINTER, 8'h86);
		wr(`SBS_OFS_STATUS, 8'h80);
		@(posedge i_core_clk);
		i_addr_indirect <= 1'b1;
		hold(1);
		chk(o_target_addr, 9'h186, "indirect upper half");
		wr(`SBS_OFS_INDIRECT, 8'h5A);
		chk(o_port_b_direction, 8'h5A, "write through pointer");
		rd(`SBS_OFS_INDIRECT, 8'h5A);
		wr(`SBS_OFS_STATUS, 8'h00);
		chk(o_target_addr, 9'h086, "indirect lower half");
		@(posedge i_core_clk);
		i_addr_indirect <= 1'b0;
		$display("test indirect done");
	endtask
	task automatic t_misc();
		rd(9'h185, 8'h00);
		rd(9'h189, 8'h00);
		wr(`SBS_OFS_PROGRAM_COUNTER_HIGH_LATCH, 8'hFF);
		chk(o_pc_high_latch, 5'h1F, "high latch five bits");
		rd(`SBS_OFS_PROGRAM_COUNTER_HIGH_LATCH, 8'h1F);
		wr(`SBS_OFS_PCL, 8'h5C);
		chk(o_pc_low, 8'h5C, "low byte output");
		wr(`SBS_OFS_NVM_UNLOCK, 8'hA5);
		chk({o_nvm_unlock_strobe, o_nvm_unlock_data}, 9'h1A5, "unlock strobe");
		hold(1);
		chk(o_nvm_unlock_strobe, 1'b0, "unlock strobe one cycle");
		rd(`SBS_OFS_NVM_UNLOCK, 8'h00);
		wr(`SBS_OFS_PRESCALE, 8'hF7);
		chk(o_timer_zero_unprescaled, 1'b0, "prescaler to timer");
		wr(`SBS_OFS_PRESCALE, 8'h08);
		chk(o_timer_zero_unprescaled, 1'b1, "prescaler to watchdog");
		$display("test misc done");
	endtask
	task automatic t_alu();
		alu(SBS_FLAG_ZDCC, 1'b0, 8'h0F, 8'h01, 1'b0);
		alu(SBS_FLAG_ZDCC, 1'b0, 8'hF0, 8'h10, 1'b0);
		alu(SBS_FLAG_ZDCC, 1'b1, 8'h05, 8'h03, 1'b0);
		alu(SBS_FLAG_ZDCC, 1'b1, 8'h03, 8'h05, 1'b0);
		alu(SBS_FLAG_Z, 1'b0, 8'h00, 8'h00, 1'b0);
		alu(SBS_FLAG_Z, 1'b0, 8'h12, 8'h00, 1'b0);
		alu(SBS_FLAG_C, 1'b0, 8'h80, 8'h00, 1'b1);
		alu(SBS_FLAG_C, 1'b0, 8'h01, 8'h00, 1'b0);
		alu(SBS_FLAG_NONE, 1'b0, 8'h00, 8'h00, 1'b0);
		alu_wr(SBS_FLAG_ZDCC, 8'h07, 8'hF0, 8'h10, 8'h1D);
		wr(`SBS_OFS_STATUS, 8'hE1);
		@(posedge i_core_clk);
		i_clear_status <= 1'b1;
		@(posedge i_core_clk);
		i_clear_status <= 1'b0;
		#1;
		chk(o_status, 8'h1D, "clear status");
		alu_wr(SBS_FLAG_Z, 8'hE2, 8'h12, 8'h00, 8'hF9);
		$display("test alu done");
	endtask
	task automatic t_power();
		@(posedge i_core_clk);
		i_sleep_instr <= 1'b1;
		@(posedge i_core_clk);
		i_sleep_instr <= 1'b0;
		#1;
		chk(o_status[4:3], 2'b10, "sleep flags");
		@(posedge i_core_clk);
		i_watchdog_clear_instr <= 1'b1;
		@(posedge i_core_clk);
		i_watchdog_clear_instr <= 1'b0;
		#1;
		chk(o_status[4:3], 2'b11, "watchdog clear flags");
		wr(`SBS_OFS_PORTB_DIR, 8'h33);
		wr(`SBS_OFS_PROGRAM_COUNTER_HIGH_LATCH, 8'h0A);
		wr(`SBS_OFS_POINTER, 8'h44);
		wr(`SBS_OFS_STATUS, 8'h63);
		@(posedge i_core_clk);
		i_watchdog_timeout <= 1'b1;
		for (n = 0; n < 20 && o_status[4] !== 1'b0; n++) hold(1);
		tmo("watchdog timeout");
		hold(2);
		chk(o_status, 8'h0B, "status after timeout");
		chk({o_port_b_direction, o_pc_high_latch[0]}, 9'h1FE, "timeout reset values");
		chk(o_pc_low, 8'h00, "low byte after timeout");
		@(posedge i_core_clk);
		i_watchdog_timeout <= 1'b0;
		rd(`SBS_OFS_POINTER, 8'h44);
		wr(`SBS_OFS_PORTB_DIR, 8'h33);
		wr(`SBS_OFS_STATUS, 8'h60);
		@(posedge i_core_clk);
		i_external_reset_pin <= 1'b1;
		for (n = 0; n < 20 && o_port_b_direction !== 8'hFF; n++) hold(1);
		tmo("pin reset");
		@(posedge i_core_clk);
		i_external_reset_pin <= 1'b0;
		hold(4);
		chk(o_status, 8'h08, "status after pin reset");
		rd(`SBS_OFS_POINTER, 8'h44);
		@(posedge i_core_clk);
		i_power_on_reset <= 1'b1;
		for (n = 0; n < 20 && o_status !== 8'h18; n++) hold(1);
		tmo("power reset");
		@(posedge i_core_clk);
		i_power_on_reset <= 1'b0;
		hold(4);
		rd(`SBS_OFS_POINTER, 8'h00);
		$display("test power done");
	endtask
	initial begin
		{i_core_clk, i_power_on_reset, i_external_reset_pin, i_watchdog_timeout, i_watchdog_clear_instr} = '0;
		{i_sleep_instr, i_wr, i_rd, i_addr_indirect, i_alu_valid, i_alu_sub, i_rot_out_bit, i_clear_status} = '0;
		{i_addr, i_wdata, i_alu_a, i_alu_b, i_alu_result, i_alu_mode} = '0;
		i_instr_addr = 7'h2A;
		i_reset = 1'b1;
		err_total = 0;
		checks_done = 0;
		repeat (5) @(posedge i_core_clk);
		i_reset <= 1'b0;
		hold(1);
		t_reset();
		t_banks();
		t_indirect();
		t_misc();
		t_alu();
		t_power();
		results();
	end
endmodule
`default_nettype wire
